// ===== mode_fsm_model.sv
`timescale 1ns/1ps
module mode_fsm_model
    import smps_pkg::*;
(
    input  logic       clock,
    input  logic       nrst,
    input  chip_mode_e mode_req,
    output chip_mode_e chip_mode
);
    // sleep and fail-safe are left only through restart, as the real mode machine does
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            chip_mode <= MODE_NORMAL;
        end else if ((chip_mode == MODE_SLEEP || chip_mode == MODE_FAILSAFE) && mode_req != MODE_RESTART) begin
            chip_mode <= chip_mode;
        end else begin
            chip_mode <= mode_req;
        end
    end
endmodule // mode_fsm_model

// ===== pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    input  logic             clock,
    input  logic             nrst,
    input  logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } sync_s;

    sync_s            s_reg;
    sync_s            s_next;
    logic [WIDTH-1:0] agree;

    if (WIDTH < 1) $error("pin_sync3 needs WIDTH of at least 1");

    always_comb begin
        s_next    = s_reg;
        s_next.s1 = pin_in;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        // a change is taken only once stages two and three agree
        agree      = ~(s_reg.s2 ^ s_reg.s3);
        s_next.out = (agree & s_reg.s3) | (~agree & s_reg.out);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level = s_reg.out;
endmodule // pin_sync3

// ===== smps_mode_control.sv
// Function
// - regulator on in normal, stop, restart only
// - buck pwm in normal, restart, stop on change
// - stop entry forces buck to pfm, except with wake select set and auto clear
// - full duty allowed while in pwm
// - soft start at power-up and wake restart
// - open loop minimum duty for some periods
// - duty rises in equal held steps, the last one capped at full duty
// - close loop once output reached
// - buck node open/short flags, no side effect
// - boost pin open/short/ground-loss flags too
// - software boost enable and four-level select
// - boost may stay on in stop, restart
// - boost on below threshold, off above hysteresis
// - boost active flag when boost switched on
// - level change while enabled ignored, sets fail
// - boost always fixed-frequency pwm
// - supervision available in normal mode
// - overvoltage drives fail output only when enabled
// - stop auto: overcurrent gives pwm, interrupt, flag
// - stop wake select: pin level picks modulation
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module smps_mode_control
    import smps_pkg::*;
#(
    parameter int HOLD_PERIODS = SS_HOLD_PERIODS
) (
    input  logic       clock,
    input  logic       nrst,
    input  chip_mode_e chip_mode,
    input  analog_in_s analog_in,
    input  wb_req_s    wb_req,
    output wb_rsp_s    wb_rsp,
    output logic       smps_enable,
    output logic       buck_pwm,
    output logic       buck_full_duty_ok,
    output logic [7:0] soft_start_duty,
    output logic       buck_loop_closed,
    output logic       boost_switch_on,
    output logic [1:0] boost_level,
    output logic       supervision_active,
    output logic       fail_output_pin,
    output logic       interrupt_out_n
);
    typedef struct packed {
        hw_ctrl_s   ctrl;
        stat_s      stat;
        logic       spi_fail;
        logic       mod_change;
        logic       pwm_latched;
        chip_mode_e mode_q;
        logic       smps_en;
        logic       start;
        logic       buck_pwm;
        logic       full_duty;
        logic       boost_on;
        logic       sup;
        logic       fail;
        logic       irq_n;
        logic       ack;
        logic [31:0] rdat;
    } main_s;

    localparam main_s MAIN_RESET = '{
        ctrl:    CTRL_RESET,
        stat:    STAT_RESET,
        mode_q:  MODE_NORMAL,
        irq_n:   1'b1,
        rdat:    32'h0000_0000,
        default: 1'b0
    };

    main_s      s_reg;
    main_s      s_next;
    analog_in_s a;
    logic [10:0] a_vec;
    logic       mode_on;
    logic       in_stop;
    logic       stop_entry;
    logic       boost_allow;
    logic       bus_req;
    logic       bus_wr;
    logic       spi_ev;
    logic       mod_ev;
    logic [5:0] stat_clr;
    logic [1:0] evt_clr;
    hw_ctrl_s   wr_ctrl;
    stat_s      stat_set;

    // comparators and fault pins are asynchronous to the clock
    pin_sync3 #(
        .WIDTH ($bits(analog_in_s))
    ) u_sync (
        .clock  (clock),
        .nrst   (nrst),
        .pin_in (analog_in),
        .level  (a_vec)
    );
    assign a = analog_in_s'(a_vec);

    soft_start_seq #(
        .HOLD_PERIODS (HOLD_PERIODS)
    ) u_soft (
        .clock       (clock),
        .nrst        (nrst),
        .enable      (s_reg.smps_en),
        .start       (s_reg.start),
        .out_reached (a.out_reached),
        .duty        (soft_start_duty),
        .loop_closed (buck_loop_closed)
    );

    always_comb begin
        s_next     = s_reg;
        spi_ev     = 1'b0;
        mod_ev     = 1'b0;
        stat_clr   = 6'h00;
        evt_clr    = 2'h0;
        wr_ctrl    = s_reg.ctrl;
        mode_on    = chip_mode == MODE_NORMAL || chip_mode == MODE_STOP
                     || chip_mode == MODE_RESTART;
        in_stop    = chip_mode == MODE_STOP;
        stop_entry = in_stop && s_reg.mode_q != MODE_STOP;

        s_next.mode_q  = chip_mode;
        s_next.smps_en = mode_on;
        // enable rising covers power-up and sleep/fail-safe to restart
        s_next.start   = mode_on && !s_reg.smps_en;

        // buck modulation
        if (!in_stop) begin
            s_next.buck_pwm    = mode_on;
            s_next.pwm_latched = 1'b0;
        end else if (s_reg.ctrl.pwm_auto) begin
            // auto wins over wake select; a new stop entry re-arms pfm
            mod_ev = !stop_entry && !s_reg.pwm_latched && a.buck_overcurrent;
            s_next.pwm_latched = !stop_entry && (s_reg.pwm_latched || a.buck_overcurrent);
            s_next.buck_pwm    = s_next.pwm_latched;
        end else if (s_reg.ctrl.wake_sel) begin
            s_next.buck_pwm    = a.wake;
            s_next.pwm_latched = 1'b0;
        end else begin
            s_next.buck_pwm    = 1'b0;
            s_next.pwm_latched = 1'b0;
        end
        s_next.full_duty = s_next.buck_pwm && mode_on;

        // boost on/off with hysteresis; switching is always fixed-frequency pwm
        boost_allow = s_reg.ctrl.boost_en && mode_on;
        if (!boost_allow) begin
            s_next.boost_on = 1'b0;
        end else if (a.vs_below_th) begin
            s_next.boost_on = 1'b1;
        end else if (a.vs_above_hyst) begin
            s_next.boost_on = 1'b0;
        end

        // supervision and fail output
        s_next.sup  = chip_mode == MODE_NORMAL;
        s_next.fail = a.ov_detect && s_reg.ctrl.ov_fail_en;

        // wishbone slave: one wait state, unmapped reads zero
        bus_req = wb_req.cyc && wb_req.stb && !s_reg.ack;
        bus_wr  = bus_req && wb_req.we && wb_req.sel[0];
        s_next.ack  = bus_req;
        s_next.rdat = 32'h0000_0000;
        if (bus_req && !wb_req.we) begin
            case (wb_req.adr[7:2])
                ADR_HW_CTRL: begin
                    s_next.rdat = {26'h0, s_reg.ctrl};
                end
                ADR_STATUS: begin
                    s_next.rdat = {26'h0, s_reg.stat};
                end
                ADR_EVENT: begin
                    s_next.rdat = {30'h0, s_reg.mod_change, s_reg.spi_fail};
                end
                default: begin
                    s_next.rdat = 32'h0000_0000;
                end
            endcase
        end
        if (bus_wr) begin
            case (wb_req.adr[7:2])
                ADR_HW_CTRL: begin
                    wr_ctrl = hw_ctrl_s'(wb_req.dat[5:0]);
                    if (s_reg.ctrl.boost_en && wr_ctrl.boost_v != s_reg.ctrl.boost_v) begin
                        spi_ev = 1'b1;
                    end else begin
                        s_next.ctrl = wr_ctrl;
                    end
                end
                ADR_STATUS: begin
                    stat_clr = wb_req.dat[5:0];
                end
                ADR_EVENT: begin
                    evt_clr = wb_req.dat[1:0];
                end
                default: begin
                    stat_clr = 6'h00;
                end
            endcase
        end
        if (chip_mode == MODE_FAILSAFE) begin
            s_next.ctrl.wake_sel = 1'b0;
        end

        // sticky flags: a new event beats a clear in the same cycle
        stat_set = '{
            boost_act:      s_reg.boost_on,
            boost_gnd_loss: a.boost_gnd_loss,
            boost_short:    a.boost_short,
            boost_open:     a.boost_open,
            buck_short:     a.buck_short,
            buck_open:      a.buck_open
        };
        s_next.stat       = stat_s'((s_reg.stat & ~stat_clr) | stat_set);
        s_next.spi_fail   = (s_reg.spi_fail && !evt_clr[0]) || spi_ev;
        s_next.mod_change = (s_reg.mod_change && !evt_clr[1]) || mod_ev;
        s_next.irq_n      = !s_next.mod_change;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= MAIN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_rsp             = '{ack: s_reg.ack, dat: s_reg.rdat};
    assign smps_enable        = s_reg.smps_en;
    assign buck_pwm           = s_reg.buck_pwm;
    assign buck_full_duty_ok  = s_reg.full_duty;
    assign boost_switch_on    = s_reg.boost_on;
    assign boost_level        = s_reg.ctrl.boost_v;
    assign supervision_active = s_reg.sup;
    assign fail_output_pin    = s_reg.fail;
    assign interrupt_out_n    = s_reg.irq_n;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_enable;
        nrst |=> smps_enable == $past(mode_on);
    endproperty
    a_enable: assert property (p_enable) else $error("regulator enable wrong for mode");

    property p_pwm_run;
        nrst && (chip_mode == MODE_NORMAL || chip_mode == MODE_RESTART) |=> buck_pwm;
    endproperty
    a_pwm_run: assert property (p_pwm_run) else $error("buck not pwm in run mode");

    property p_stop_entry;
        stop_entry && !s_reg.ctrl.wake_sel |=> !buck_pwm;
    endproperty
    a_stop_entry: assert property (p_stop_entry) else $error("buck not pfm on stop entry");

    property p_full_duty;
        1'b1 |-> buck_full_duty_ok == (buck_pwm && smps_enable);
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty permission wrong");

    sequence s_power_on;
        !smps_enable ##1 smps_enable;
    endsequence
    property p_soft_start;
        s_power_on |-> s_reg.start ##1 !s_reg.start;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("soft start not launched");

    property p_boost_on;
        s_reg.ctrl.boost_en && mode_on && a.vs_below_th |=> boost_switch_on;
    endproperty
    a_boost_on: assert property (p_boost_on) else $error("boost did not switch on");

    property p_boost_off;
        !s_reg.ctrl.boost_en || !mode_on |=> !boost_switch_on;
    endproperty
    a_boost_off: assert property (p_boost_off) else $error("boost on while not allowed");

    property p_boost_flag;
        boost_switch_on |=> s_reg.stat.boost_act;
    endproperty
    a_boost_flag: assert property (p_boost_flag) else $error("boost active flag missing");

    sequence s_bad_level_write;
        bus_wr && wb_req.adr[7:2] == ADR_HW_CTRL && s_reg.ctrl.boost_en
            && wb_req.dat[2:1] != s_reg.ctrl.boost_v;
    endsequence
    property p_level_guard;
        s_bad_level_write |=> $stable(s_reg.ctrl) && s_reg.spi_fail;
    endproperty
    a_level_guard: assert property (p_level_guard) else $error("guarded level write not refused");

    property p_fail_out;
        1'b1 |=> fail_output_pin == $past(a.ov_detect && s_reg.ctrl.ov_fail_en);
    endproperty
    a_fail_out: assert property (p_fail_out) else $error("fail output wrong");

    property p_auto_pwm;
        in_stop && !stop_entry && s_reg.ctrl.pwm_auto && a.buck_overcurrent
            |=> buck_pwm && ($past(s_reg.pwm_latched) || (s_reg.mod_change && !interrupt_out_n));
    endproperty
    a_auto_pwm: assert property (p_auto_pwm) else $error("auto pwm transition missing");

    property p_wake_pwm;
        in_stop && !s_reg.ctrl.pwm_auto && s_reg.ctrl.wake_sel |=> buck_pwm == $past(a.wake);
    endproperty
    a_wake_pwm: assert property (p_wake_pwm) else $error("wake pin modulation wrong");

    property p_sup;
        nrst && chip_mode == MODE_NORMAL |=> supervision_active;
    endproperty
    a_sup: assert property (p_sup) else $error("supervision off in normal mode");

    // a fault flag survives until software clears it
    property p_fault_sticky;
        s_reg.stat.buck_short && !(bus_wr && wb_req.adr[7:2] == ADR_STATUS && wb_req.dat[1])
            |=> s_reg.stat.buck_short;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("buck short flag lost");

    property p_boost_gnd_flag;
        a.boost_gnd_loss |=> s_reg.stat.boost_gnd_loss;
    endproperty
    a_boost_gnd_flag: assert property (p_boost_gnd_flag) else $error("boost ground loss flag missing");

    property p_level_write;
        bus_wr && wb_req.adr[7:2] == ADR_HW_CTRL && !s_reg.ctrl.boost_en
            |=> boost_level == $past(wb_req.dat[2:1]);
    endproperty
    a_level_write: assert property (p_level_write) else $error("boost level write not taken");

    property p_irq_level;
        1'b1 |-> interrupt_out_n == !s_reg.mod_change;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_failsafe_wake;
        chip_mode == MODE_FAILSAFE |=> !s_reg.ctrl.wake_sel;
    endproperty
    a_failsafe_wake: assert property (p_failsafe_wake) else $error("wake select kept in fail-safe");

    property p_ack;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack ##1 !wb_rsp.ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing wrong");
endmodule // smps_mode_control

// ===== smps_mode_control_tb.sv
`timescale 1ns/1ps
module smps_mode_control_tb;
    import smps_pkg::*;
    localparam int HOLD = 1;
    logic       clock = 1'b0;
    logic       nrst = 1'b0;
    chip_mode_e mode_req = MODE_NORMAL;
    chip_mode_e chip_mode;
    analog_in_s analog_in = '0;
    wb_req_s    wb_req = '0;
    wb_rsp_s    wb_rsp;
    logic       smps_enable, buck_pwm, buck_full_duty_ok, buck_loop_closed, boost_switch_on;
    logic       supervision_active, fail_output_pin, interrupt_out_n;
    logic [7:0] soft_start_duty;
    logic [1:0] boost_level;
    logic [31:0] rd;
    int         failures = 0;
    int         n_tests = 0;
    chip_mode_e seq [8] = '{MODE_NORMAL, MODE_STOP, MODE_RESTART, MODE_SLEEP,
                            MODE_RESTART, MODE_FAILSAFE, MODE_RESTART, MODE_NORMAL};

    always #4 clock = ~clock;

    mode_fsm_model mode_src (.clock(clock), .nrst(nrst), .mode_req(mode_req), .chip_mode(chip_mode));

    smps_mode_control #(.HOLD_PERIODS(HOLD)) DUT (
        .clock(clock), .nrst(nrst), .chip_mode(chip_mode), .analog_in(analog_in),
        .wb_req(wb_req), .wb_rsp(wb_rsp), .smps_enable(smps_enable), .buck_pwm(buck_pwm),
        .buck_full_duty_ok(buck_full_duty_ok), .soft_start_duty(soft_start_duty),
        .buck_loop_closed(buck_loop_closed), .boost_switch_on(boost_switch_on),
        .boost_level(boost_level), .supervision_active(supervision_active),
        .fail_output_pin(fail_output_pin), .interrupt_out_n(interrupt_out_n));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one classic cycle; read data is taken at the ack edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
        do begin
            @(posedge clock);
        end while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clock);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        wrap_up();
    end

    initial begin
        int i;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        tick(3);
        check("duty_min", soft_start_duty, SS_MIN_DUTY);
        check("loop_open", buck_loop_closed, 1'b0);
        for (i = 0; i < 700 && soft_start_duty === SS_MIN_DUTY; i++) @(posedge clock);
        check("duty_step", soft_start_duty, SS_MIN_DUTY + SS_STEP);
        analog_in.out_reached <= 1'b1;
        tick(8);
        check("loop_closed", buck_loop_closed, 1'b1);
        check("full_duty", buck_full_duty_ok, 1'b1);
        for (i = 0; i < 4; i++) begin
            wb(1'b0, 8'(i * 4), '0);
            check("reg_reset", rd, '0);
        end
        analog_in.out_reached <= 1'b0;
        for (i = 0; i < 8; i++) begin
            mode_req <= seq[i];
            tick(4);
            check("enable", smps_enable, seq[i] inside {MODE_NORMAL, MODE_STOP, MODE_RESTART});
            check("supervision", supervision_active, seq[i] == MODE_NORMAL);
            if (smps_enable === 1'b1) check("pwm", buck_pwm, seq[i] != MODE_STOP);
            if (i > 2 && seq[i] == MODE_RESTART) check("restart_duty", soft_start_duty, SS_MIN_DUTY);
        end
        analog_in.out_reached <= 1'b1;
        wb(1'b1, 8'h00, 32'h5);
        tick(2);
        check("boost_level", boost_level, 2'h2);
        wb(1'b1, 8'h00, 32'h7);
        wb(1'b0, 8'h00, '0);
        check("ctrl_kept", rd, 32'h5);
        wb(1'b0, 8'h08, '0);
        check("spi_fail", rd[0], 1'b1);
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b0, 8'h08, '0);
        check("event_clear", rd, '0);
        analog_in.vs_below_th <= 1'b1;
        tick(6);
        check("boost_on", boost_switch_on, 1'b1);
        mode_req <= MODE_STOP;
        tick(4);
        check("boost_stop", boost_switch_on, 1'b1);
        mode_req <= MODE_NORMAL;
        analog_in.vs_below_th <= 1'b0;
        analog_in.vs_above_hyst <= 1'b1;
        tick(6);
        check("boost_off", boost_switch_on, 1'b0);
        analog_in.vs_above_hyst <= 1'b0;
        analog_in.buck_open <= 1'b1;
        analog_in.buck_short <= 1'b1;
        analog_in.boost_open <= 1'b1;
        analog_in.boost_short <= 1'b1;
        analog_in.boost_gnd_loss <= 1'b1;
        tick(6);
        analog_in[10:6] <= '0;
        // let the cleared faults pass the synchroniser before the clear
        tick(4);
        wb(1'b0, 8'h04, '0);
        check("status", rd, 32'h3F);
        check("no_side_effect", smps_enable, 1'b1);
        wb(1'b1, 8'h04, 32'h3F);
        wb(1'b0, 8'h04, '0);
        check("status_clear", rd, '0);
        analog_in.ov_detect <= 1'b1;
        tick(6);
        check("fail_masked", fail_output_pin, 1'b0);
        wb(1'b1, 8'h00, 32'h25);
        tick(2);
        check("fail_drive", fail_output_pin, 1'b1);
        analog_in.ov_detect <= 1'b0;
        wb(1'b1, 8'h00, 32'h4);
        wb(1'b1, 8'h00, 32'h8);
        mode_req <= MODE_STOP;
        tick(4);
        check("stop_pfm", buck_pwm, 1'b0);
        analog_in.buck_overcurrent <= 1'b1;
        tick(6);
        check("auto_pwm", buck_pwm, 1'b1);
        check("irq", interrupt_out_n, 1'b0);
        wb(1'b0, 8'h08, '0);
        check("mod_flag", rd[1], 1'b1);
        analog_in.buck_overcurrent <= 1'b0;
        wb(1'b1, 8'h08, 32'h2);
        tick(2);
        check("irq_clear", interrupt_out_n, 1'b1);
        mode_req <= MODE_NORMAL;
        wb(1'b1, 8'h00, 32'h10);
        mode_req <= MODE_STOP;
        for (i = 0; i < 2; i++) begin
            analog_in.wake <= i[0];
            tick(6);
            check("wake_pwm", buck_pwm, i[0]);
        end
        mode_req <= MODE_FAILSAFE;
        tick(4);
        wb(1'b0, 8'h00, '0);
        check("wake_sel_cleared", rd, 32'h0);
        wrap_up();
    end
endmodule // smps_mode_control_tb

// ===== smps_pkg.sv
package smps_pkg;
    localparam int CLOCK_KHZ        = 125000;
    localparam int BUCK_FREQ_KHZ    = 450;
    localparam int SW_PERIOD_CYCLES = CLOCK_KHZ / BUCK_FREQ_KHZ;
    localparam int SS_HOLD_PERIODS  = 4;
    localparam logic [7:0] SS_MIN_DUTY = 8'h10;
    localparam logic [7:0] SS_STEP     = 8'h08;
    localparam logic [7:0] DUTY_FULL   = 8'hFF;
    localparam logic [5:0] ADR_HW_CTRL = 6'h00;
    localparam logic [5:0] ADR_STATUS  = 6'h01;
    localparam logic [5:0] ADR_EVENT   = 6'h02;
    localparam logic [5:0] CTRL_RESET  = 6'h00;
    localparam logic [5:0] STAT_RESET  = 6'h00;

    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'h0,
        MODE_STOP     = 3'h1,
        MODE_RESTART  = 3'h2,
        MODE_SLEEP    = 3'h3,
        MODE_FAILSAFE = 3'h4
    } chip_mode_e;

    typedef enum logic [1:0] {
        SS_IDLE = 2'h0,
        SS_MIN  = 2'h1,
        SS_RAMP = 2'h3,
        SS_DONE = 2'h2
    } soft_state_e;

    // bit 0 upward: boost_en, boost_v[1:0], pwm_auto, wake select, ov fail
    typedef struct packed {
        logic       ov_fail_en;
        logic       wake_sel;
        logic       pwm_auto;
        logic [1:0] boost_v;
        logic       boost_en;
    } hw_ctrl_s;

    typedef struct packed {
        logic boost_act;
        logic boost_gnd_loss;
        logic boost_short;
        logic boost_open;
        logic buck_short;
        logic buck_open;
    } stat_s;

    typedef struct packed {
        logic buck_open;
        logic buck_short;
        logic boost_open;
        logic boost_short;
        logic boost_gnd_loss;
        logic vs_below_th;
        logic vs_above_hyst;
        logic buck_overcurrent;
        logic out_reached;
        logic ov_detect;
        logic wake;
    } analog_in_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;
endpackage

// ===== soft_start_seq.sv
`timescale 1ns/1ps
module soft_start_seq
    import smps_pkg::*;
#(
    parameter int         HOLD_PERIODS = SS_HOLD_PERIODS,
    parameter int         PERIOD       = SW_PERIOD_CYCLES,
    parameter logic [7:0] MIN_DUTY     = SS_MIN_DUTY,
    parameter logic [7:0] STEP         = SS_STEP
) (
    input  logic       clock,
    input  logic       nrst,
    input  logic       enable,
    input  logic       start,
    input  logic       out_reached,
    output logic [7:0] duty,
    output logic       loop_closed
);
    typedef struct packed {
        soft_state_e st;
        logic [7:0]  duty;
        logic [8:0]  per_cnt;
        logic [7:0]  hold;
        logic        closed;
    } ss_s;

    ss_s        s_reg;
    ss_s        s_next;
    logic       period_end;
    logic [8:0] sum;

    if (HOLD_PERIODS < 1 || HOLD_PERIODS > 256 || PERIOD < 2 || PERIOD > 512 || STEP == 8'h00)
        $error("soft_start_seq parameters out of range");

    always_comb begin
        s_next         = s_reg;
        period_end     = s_reg.per_cnt == 9'(PERIOD - 1);
        s_next.per_cnt = period_end ? 9'h000 : s_reg.per_cnt + 9'h001;
        sum            = {1'b0, s_reg.duty} + {1'b0, STEP};
        case (s_reg.st)
            SS_IDLE: begin
                s_next.per_cnt = 9'h000;
                if (start) begin
                    s_next.st     = SS_MIN;
                    s_next.duty   = MIN_DUTY;
                    s_next.hold   = 8'h00;
                    s_next.closed = 1'b0;
                end
            end
            SS_MIN, SS_RAMP: begin
                if (out_reached) begin
                    s_next.st     = SS_DONE;
                    s_next.closed = 1'b1;
                end else if (period_end) begin
                    s_next.hold = s_reg.hold + 8'h01;
                    if (s_reg.hold == 8'(HOLD_PERIODS - 1)) begin
                        s_next.hold = 8'h00;
                        s_next.st   = SS_RAMP;
                        s_next.duty = sum[8] ? DUTY_FULL : sum[7:0];
                    end
                end
            end
            SS_DONE: begin
                s_next.closed  = 1'b1;
                s_next.per_cnt = 9'h000;
            end
            default: begin
                s_next.st = SS_IDLE;
            end
        endcase
        if (!enable) begin
            s_next = '0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign duty        = s_reg.duty;
    assign loop_closed = s_reg.closed;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_go;
        enable && start && s_reg.st == SS_IDLE;
    endsequence
    sequence s_min_phase;
        s_reg.st == SS_MIN && s_reg.duty == MIN_DUTY;
    endsequence

    property p_min_start;
        s_go ##1 enable |-> s_min_phase;
    endproperty
    a_min_start: assert property (p_min_start) else $error("soft start did not open at minimum duty");

    property p_step;
        s_reg.st == SS_RAMP && $changed(s_reg.duty) && enable
            |-> s_reg.duty == DUTY_FULL || s_reg.duty == $past(s_reg.duty) + STEP;
    endproperty
    a_step: assert property (p_step) else $error("duty step size wrong");

    property p_hold;
        s_reg.st == SS_RAMP && $changed(s_reg.duty) |=> ($stable(s_reg.duty) || !enable) [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("duty step not held");

    property p_close;
        enable && out_reached && (s_reg.st == SS_MIN || s_reg.st == SS_RAMP) |=> loop_closed;
    endproperty
    a_close: assert property (p_close) else $error("loop not closed on target");
endmodule // soft_start_seq
